//--- dib_params.svh
// timing counts and field positions for the bank sequencer
`ifndef DIB_PARAMS_SVH
`define DIB_PARAMS_SVH
`define DIB_NUM_BANKS     8
`define DIB_BA_W          3
`define DIB_ADDR_W        14
`define DIB_ROW_W         14
`define DIB_AP_BIT        10
`define DIB_MR_COUNT      4
`define DIB_T_RCD         2
`define DIB_T_RP          2
`define DIB_T_WR          3
`define DIB_T_MRD         2
`define DIB_CL            3
`define DIB_BL            4
`define DIB_WTR_MIN       2
`define DIB_CNT_W         5
`endif

//--- dib_pkg.sv
// types for the interbank command sequencer
package dib_pkg;
  typedef enum logic [2:0] {
    CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_LM
  } dib_cmd_e;
  typedef enum logic [2:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING, BK_PRECHARGING
  } dib_bank_e;
endpackage

//--- dib_bank_seq.sv
// command decode and per-bank state sequencing of a ddr2 device
`timescale 1ns/10ps
`default_nettype none
`include "dib_params.svh"
module dib_bank_seq
  import dib_pkg::*;
#(
  parameter int NB = `DIB_NUM_BANKS,
  parameter int AW = `DIB_ADDR_W
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 mem_ck,
  input  wire logic                 cke,
  input  wire logic                 cs_n,
  input  wire logic                 ras_n,
  input  wire logic                 cas_n,
  input  wire logic                 we_n,
  input  wire logic [`DIB_BA_W-1:0] ba,
  input  wire logic [AW-1:0]        addr,
  output logic [3*NB-1:0]           bank_state,
  output logic [NB-1:0]             bank_open,
  output logic [AW-1:0]             open_row,
  output logic [AW-1:0]             mode_reg0,
  output logic [AW-1:0]             mode_reg1,
  output logic [AW-1:0]             mode_reg2,
  output logic [AW-1:0]             mode_reg3,
  output logic                      cmd_valid,
  output logic [2:0]                cmd_code,
  output logic                      illegal_cmd,
  output logic                      mrd_busy
);
  import dib_pkg::*;

  localparam int CW = `DIB_CNT_W;
  localparam logic [CW-1:0] RCD_C = CW'(`DIB_T_RCD);
  localparam logic [CW-1:0] RP_C  = CW'(`DIB_T_RP);
  localparam logic [CW-1:0] MRD_C = CW'(`DIB_T_MRD);
  localparam logic [CW-1:0] BL2_C = CW'(`DIB_BL / 2);
  // read-AP precharge point: burst length / 2 after the read
  localparam logic [CW-1:0] RAP_C = BL2_C;
  // write-AP precharge point: write latency + burst + recovery
  localparam logic [CW-1:0] WAP_C = CW'((`DIB_CL - 1) + (`DIB_BL / 2) + `DIB_T_WR);
  localparam logic [CW-1:0] RDB_C = CW'(`DIB_CL + (`DIB_BL / 2));
  localparam logic [CW-1:0] WRB_C = CW'((`DIB_CL - 1) + (`DIB_BL / 2));

  typedef struct packed {
    logic [2:0]                     ck_sync;
    logic                           cke_s1;
    logic                           cke_s2;
    logic [3:0]                     pin_s1;
    logic [3:0]                     pin_s2;
    logic [`DIB_BA_W-1:0]           ba_s1;
    logic [`DIB_BA_W-1:0]           ba_s2;
    logic [AW-1:0]                  a_s1;
    logic [AW-1:0]                  a_s2;
    logic                           cke_prev;
    logic [NB-1:0][2:0]             st;
    logic [NB-1:0][CW-1:0]          cnt;
    logic [NB-1:0]                  ap;
    logic [NB-1:0][AW-1:0]          row;
    logic [`DIB_MR_COUNT-1:0][AW-1:0] mr;
    logic [CW-1:0]                  mrd_cnt;
    logic                           vld;
    logic [2:0]                     code;
    logic                           bad;
  } dib_state_s;

  dib_state_s s_q, s_d;
  dib_cmd_e   cmd;
  logic       ck_rise;
  logic       all_idle;
  logic [AW-1:0] row_sel;

  assign ck_rise = s_q.ck_sync[1] & ~s_q.ck_sync[2];

  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < NB; i++) begin
      if (s_q.st[i] != 3'(BK_IDLE)) begin
        all_idle = 1'b0;
      end
    end
  end

  // decode of the synchronised pins
  always_comb begin
    if (s_q.pin_s2[3]) begin
      cmd = CMD_DESEL;
    end else begin
      case (s_q.pin_s2[2:0])
        3'b111:  cmd = CMD_NOP;
        3'b011:  cmd = CMD_ACT;
        3'b101:  cmd = CMD_RD;
        3'b100:  cmd = CMD_WR;
        3'b010:  cmd = CMD_PRE;
        3'b001:  cmd = CMD_REF;
        3'b000:  cmd = CMD_LM;
        default: cmd = CMD_NOP;
      endcase
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.ck_sync = {s_q.ck_sync[1], s_q.ck_sync[0], mem_ck};
    s_d.cke_s1 = cke;
    s_d.cke_s2 = s_q.cke_s1;
    s_d.pin_s1 = {cs_n, ras_n, cas_n, we_n};
    s_d.pin_s2 = s_q.pin_s1;
    s_d.ba_s1 = ba;
    s_d.ba_s2 = s_q.ba_s1;
    s_d.a_s1 = addr;
    s_d.a_s2 = s_q.a_s1;
    s_d.vld = 1'b0;
    s_d.bad = 1'b0;
    if (ck_rise) begin
      s_d.cke_prev = s_q.cke_s2;
      if (s_q.mrd_cnt != '0) begin
        s_d.mrd_cnt = s_q.mrd_cnt - CW'(1);
      end
      // running operations advance regardless of the command
      for (int i = 0; i < NB; i++) begin
        if (s_q.cnt[i] != '0) begin
          s_d.cnt[i] = s_q.cnt[i] - CW'(1);
        end else begin
          case (dib_bank_e'(s_q.st[i]))
            BK_ACTIVATING:  s_d.st[i] = 3'(BK_ACTIVE);
            BK_PRECHARGING: s_d.st[i] = 3'(BK_IDLE);
            BK_READING, BK_WRITING: begin
              if (s_q.ap[i]) begin
                s_d.st[i]  = 3'(BK_PRECHARGING);
                s_d.cnt[i] = RP_C - CW'(1);
                s_d.ap[i]  = 1'b0;
              end else begin
                s_d.st[i] = 3'(BK_ACTIVE);
              end
            end
            default: s_d.st[i] = s_q.st[i];
          endcase
        end
      end
      if (s_q.cke_prev && s_q.cke_s2 && cmd != CMD_DESEL && cmd != CMD_NOP) begin
        s_d.vld  = 1'b1;
        s_d.code = 3'(cmd);
        if (s_q.mrd_cnt != '0) begin
          s_d.bad = 1'b1;
        end else begin
          case (cmd)
            CMD_ACT: begin
              if (s_q.st[s_q.ba_s2] == 3'(BK_IDLE)) begin
                s_d.st[s_q.ba_s2]  = 3'(BK_ACTIVATING);
                s_d.cnt[s_q.ba_s2] = RCD_C - CW'(1);
                s_d.row[s_q.ba_s2] = s_q.a_s2;
              end else begin
                s_d.bad = 1'b1;
              end
            end
            CMD_RD, CMD_WR: begin
              if (s_q.st[s_q.ba_s2] == 3'(BK_ACTIVE) ||
                  ((s_q.st[s_q.ba_s2] == 3'(BK_READING) ||
                    s_q.st[s_q.ba_s2] == 3'(BK_WRITING)) && !s_q.ap[s_q.ba_s2])) begin
                s_d.st[s_q.ba_s2]  = (cmd == CMD_RD) ? 3'(BK_READING) : 3'(BK_WRITING);
                s_d.ap[s_q.ba_s2]  = s_q.a_s2[`DIB_AP_BIT];
                if (s_q.a_s2[`DIB_AP_BIT]) begin
                  s_d.cnt[s_q.ba_s2] = (cmd == CMD_RD) ? RAP_C : WAP_C;
                end else begin
                  s_d.cnt[s_q.ba_s2] = (cmd == CMD_RD) ? RDB_C : WRB_C;
                end
              end else begin
                s_d.bad = 1'b1;
              end
            end
            CMD_PRE: begin
              if (s_q.a_s2[`DIB_AP_BIT]) begin
                for (int i = 0; i < NB; i++) begin
                  if (s_q.st[i] != 3'(BK_IDLE)) begin
                    s_d.st[i]  = 3'(BK_PRECHARGING);
                    s_d.cnt[i] = RP_C - CW'(1);
                    s_d.ap[i]  = 1'b0;
                  end
                end
              end else if (s_q.st[s_q.ba_s2] != 3'(BK_IDLE)) begin
                s_d.st[s_q.ba_s2]  = 3'(BK_PRECHARGING);
                s_d.cnt[s_q.ba_s2] = RP_C - CW'(1);
                s_d.ap[s_q.ba_s2]  = 1'b0;
              end
            end
            CMD_REF: begin
              if (!all_idle) begin
                s_d.bad = 1'b1;
              end
            end
            CMD_LM: begin
              if (all_idle) begin
                s_d.mr[s_q.ba_s2[1:0]] = s_q.a_s2;
                s_d.mrd_cnt = MRD_C;
              end else begin
                s_d.bad = 1'b1;
              end
            end
            default: s_d.bad = 1'b0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign row_sel = s_q.row[s_q.ba_s2];

  always_comb begin
    for (int i = 0; i < NB; i++) begin
      bank_state[3*i +: 3] = s_q.st[i];
      bank_open[i] = (s_q.st[i] != 3'(BK_IDLE)) && (s_q.st[i] != 3'(BK_PRECHARGING));
    end
  end

  assign open_row    = row_sel;
  assign mode_reg0   = s_q.mr[0];
  assign mode_reg1   = s_q.mr[1];
  assign mode_reg2   = s_q.mr[2];
  assign mode_reg3   = s_q.mr[3];
  assign cmd_valid   = s_q.vld;
  assign cmd_code    = s_q.code;
  assign illegal_cmd = s_q.bad;
  assign mrd_busy    = s_q.mrd_cnt != '0;
endmodule // dib_bank_seq
`default_nettype wire

//--- dib_bank_seq_sva.sv
// port assertions for the bank sequencer
`timescale 1ns/10ps
`default_nettype none
module dib_bank_seq_sva #(parameter int NB = 8, parameter int AW = 14) (
  input wire logic            clk,
  input wire logic            sys_rst,
  input wire logic [3*NB-1:0] bank_state,
  input wire logic [NB-1:0]   bank_open,
  input wire logic [AW-1:0]   mode_reg0,
  input wire logic            cmd_valid,
  input wire logic [2:0]      cmd_code,
  input wire logic            illegal_cmd,
  input wire logic            mrd_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [NB-1:0] open_exp;
  logic          state_ok;
  wire logic     ok_cmd = cmd_valid && !illegal_cmd;
  always_comb begin
    state_ok = 1'b1;
    for (int i = 0; i < NB; i++) begin
      open_exp[i] = !(bank_state[3*i+:3] inside {3'h0, 3'h5});
      state_ok &= (bank_state[3*i+:3] <= 3'h5);
    end
  end
  a_valid_pulse: assert property (cmd_valid |=> !cmd_valid [*6])
    else $error("command pulses too close");
  a_illegal_flag: assert property (illegal_cmd |-> cmd_valid)
    else $error("illegal flag without command");
  a_code_hold: assert property (!cmd_valid |-> $stable(cmd_code))
    else $error("code moved without command");
  a_code_range: assert property (cmd_valid |-> cmd_code inside {[3'h2:3'h7]})
    else $error("bad command code");
  a_mode_write: assert property ($changed(mode_reg0) |-> ok_cmd && cmd_code == 3'h7)
    else $error("mode register moved without load");
  a_mode_busy: assert property (ok_cmd && cmd_code == 3'h7 |-> ##[0:1] mrd_busy ##[1:24] !mrd_busy)
    else $error("mode delay wrong");
  a_open_match: assert property (bank_open == open_exp && state_ok)
    else $error("bank open flags disagree with states");
  a_refresh_idle: assert property (ok_cmd && cmd_code == 3'h6 |-> bank_open == '0)
    else $error("refresh taken with open bank");
  a_act_open: assert property (ok_cmd && cmd_code == 3'h2 |-> bank_open != '0)
    else $error("activate left no bank open");
endmodule // dib_bank_seq_sva
`default_nettype wire

//--- dib_ctrl_model.sv
// memory controller model for the command pins
`timescale 1ns/10ps
`default_nettype none
module dib_ctrl_model (
  input  wire logic   clk,
  output logic        mem_ck,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [13:0] addr
);
  import dib_pkg::*;
  int         seed = 18636;
  logic [3:0] enc [8] = '{4'h8, 4'h7, 4'h3, 4'h5, 4'h4, 4'h2, 4'h1, 4'h0};
  initial begin
    {mem_ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr} = 23'h1e0000;
    #33;
    forever #80 mem_ck = ~mem_ck;
  end
  // pins change after a memory clock fall, held through the next rise
  task automatic issue(input dib_cmd_e c, input logic [2:0] b, input logic [13:0] a,
                       input logic k);
    @(negedge mem_ck);
    @(negedge clk);
    cke = k;
    {cs_n, ras_n, cas_n, we_n, ba, addr} = (c == CMD_DESEL) ?
      {1'b1, 20'($random(seed))} : {enc[c], b, a};
  endtask
endmodule // dib_ctrl_model
`default_nettype wire

//--- tb_dib_bank_seq.sv
// self-checking bench for the bank sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_dib_bank_seq;
  import dib_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        mem_ck, cke, cs_n, ras_n, cas_n, we_n, cmd_valid, illegal_cmd, mrd_busy;
  logic [2:0]  ba, cmd_code;
  logic [13:0] addr, open_row, mode_reg0, mode_reg1, mode_reg2, mode_reg3;
  logic [23:0] bank_state;
  logic [7:0]  bank_open;
  int          mismatches = 0;
  int          compares = 0;
  logic [3:0]  exp_q [$];
  always #10 clk = ~clk;
  dib_ctrl_model u_ctrl (.clk, .mem_ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);
  dib_bank_seq dut (.clk, .sys_rst, .mem_ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
    .bank_state, .bank_open, .open_row, .mode_reg0, .mode_reg1, .mode_reg2, .mode_reg3,
    .cmd_valid, .cmd_code, .illegal_cmd, .mrd_busy);
  task automatic check(input string n, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // drive one command and note the answer it should get
  task automatic cmd(input dib_cmd_e c, input logic [2:0] b, input logic [13:0] a,
                     input logic bad);
    u_ctrl.issue(c, b, a, 1'b1);
    if (c > CMD_NOP) exp_q.push_back({bad, 3'(c)});
  endtask
  task automatic idle(input int n);
    repeat (n) u_ctrl.issue(CMD_DESEL, 3'h0, 14'h0, 1'b1);
  endtask
  function automatic logic [23:0] st(input int i);
    return 24'(bank_state[3*i+:3]);
  endfunction
  always @(negedge clk) begin
    if (cmd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected command", 24'h1, 24'h0);
      else check("command", 24'({illegal_cmd, cmd_code}), 24'(exp_q.pop_front()));
    end
  end
  initial begin
    #50000;
    check("timeout", 24'h1, 24'h0);
    test_done();
  end
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    check("reset state", bank_state, 24'h0);
    u_ctrl.issue(CMD_ACT, 3'h0, 14'h0, 1'b0);
    u_ctrl.issue(CMD_ACT, 3'h0, 14'h0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      cmd(CMD_LM, 3'(i), 14'(12'h5a0 + i), 1'b0);
      idle(2);
    end
    check("mode0", 24'(mode_reg0), 24'h5a0);
    check("mode2", 24'(mode_reg2), 24'h5a2);
    check("mode3", 24'(mode_reg3), 24'h5a3);
    cmd(CMD_LM, 3'h1, 14'h0042, 1'b0);
    cmd(CMD_ACT, 3'h0, 14'h1abc, 1'b1);
    check("mode busy", 24'(mrd_busy), 24'h1);
    idle(2);
    check("mode free", 24'(mrd_busy), 24'h0);
    check("mode1", 24'(mode_reg1), 24'h42);
    check("refused act", bank_state, 24'h0);
    cmd(CMD_REF, 3'h0, 14'h0, 1'b0);
    cmd(CMD_RD, 3'h3, 14'h0, 1'b1);
    cmd(CMD_PRE, 3'h3, 14'h0, 1'b0);
    cmd(CMD_ACT, 3'h0, 14'h1abc, 1'b0);
    cmd(CMD_ACT, 3'h0, 14'h0001, 1'b1);
    check("activating", st(0), 24'h1);
    cmd(CMD_NOP, 3'h0, 14'h0, 1'b0);
    cmd(CMD_NOP, 3'h0, 14'h0, 1'b0);
    check("active", st(0), 24'h2);
    check("open flags", 24'(bank_open), 24'h1);
    check("open row", 24'(open_row), 24'h1abc);
    cmd(CMD_REF, 3'h0, 14'h0, 1'b1);
    cmd(CMD_LM, 3'h0, 14'h0, 1'b1);
    cmd(CMD_ACT, 3'h1, 14'h0222, 1'b0);
    cmd(CMD_RD, 3'h0, 14'h0400, 1'b0);
    cmd(CMD_ACT, 3'h2, 14'h0333, 1'b0);
    check("reading", st(0), 24'h3);
    idle(4);
    check("read precharge", st(0), 24'h5);
    idle(2);
    check("read idle", st(0), 24'h0);
    cmd(CMD_WR, 3'h1, 14'h0400, 1'b0);
    idle(7);
    check("writing", st(1), 24'h4);
    idle(2);
    check("write precharge", st(1), 24'h5);
    idle(2);
    check("write idle", st(1), 24'h0);
    cmd(CMD_PRE, 3'h2, 14'h0, 1'b0);
    idle(4);
    check("all idle", bank_state, 24'h0);
    check("all closed", 24'(bank_open), 24'h0);
    check("pending", 24'(exp_q.size()), 24'h0);
    test_done();
  end
endmodule // tb_dib_bank_seq
bind dib_bank_seq dib_bank_seq_sva #(.NB(NB), .AW(AW)) u_sva (.clk, .sys_rst, .bank_state,
  .bank_open, .mode_reg0, .cmd_valid, .cmd_code, .illegal_cmd, .mrd_busy);
`default_nettype wire
